// *** verilog/scw_pkg.sv ***
/*
 * Package for the serial configuration register writer: register
 * addresses, payload lengths and reset values.
 * Assumes a byte source that presents one received byte per strobe.
 */
package scw_pkg;
    localparam logic [7:0] ADDR_REINIT = 8'h01;
    localparam logic [7:0] ADDR_LED = 8'h02;
    localparam logic [7:0] ADDR_SYNTH = 8'h03;
    localparam logic [7:0] ADDR_TONE_LIST = 8'h04;
    localparam logic [7:0] ADDR_SEQ_CFG = 8'h05;
    localparam logic [7:0] ADDR_SWEEP_FIRST = 8'h06;
    localparam logic [7:0] ADDR_SWEEP_LAST = 8'h07;
    localparam logic [7:0] ADDR_SWEEP_INC = 8'h08;
    localparam logic [7:0] ADDR_HOLD_TIME = 8'h09;
    localparam logic [7:0] ADDR_REPEAT = 8'h0A;
    localparam logic [7:0] ADDR_UNUSED_0B = 8'h0B;
    localparam logic [7:0] ADDR_TABLE_TOTAL = 8'h0C;
    localparam logic [7:0] ADDR_TABLE_PUSH = 8'h0D;
    localparam logic [7:0] ADDR_TABLE_XFER = 8'h0E;
    localparam logic [7:0] ADDR_HOST_TRIG = 8'h0F;
    localparam logic [7:0] ADDR_FREQ = 8'h10;
    localparam logic [7:0] ADDR_POWER = 8'h11;
    localparam logic [7:0] ADDR_OUT_ON = 8'h12;

    localparam logic [2:0] LEN_BYTE1 = 3'h1;
    localparam logic [2:0] LEN_BYTE3 = 3'h3;
    localparam logic [2:0] LEN_BYTE5 = 3'h5;
    localparam logic [2:0] LEN_BYTE7 = 3'h7;

    localparam int REINIT_MODE_BIT = 0;

    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [23:0] RST_W24 = 24'h000000;
    localparam logic [39:0] RST_W40 = 40'h0000000000;
    localparam logic [55:0] RST_W56 = 56'h00000000000000;
    localparam logic [2:0] RST_COUNT = 3'h0;

    typedef enum logic [1:0] {
        SCW_ADDR = 2'b00,
        SCW_DATA = 2'b01,
        SCW_STALL = 2'b10
    } scw_state_e;
endpackage : scw_pkg

// *** verilog/scw_writer.sv ***
/*
 * Serial configuration register writer. Frames received bytes into an
 * address byte plus a fixed payload and loads the addressed register.
 * Assumes an SPI or RS232 receiver on the same clock delivering bytes
 * with a one-cycle strobe, most significant payload byte first.
 */
`timescale 1ns/1ps

// Overview of operation
// - Registers are write-only; no readback path exists.
// - Each register has its own fixed payload length on all links.
// - Wrong length misframes following bytes; unknown address stalls.
// - Transfer is one address byte then that register's payload bytes.
// - Frequency write is eight bytes: address plus seven payload bytes.
// - Reinit bit 0: zero keeps settings, one returns to power-up.
module scw_writer (
    input wire logic i_clock,
    input wire logic i_reset_n,
    input wire logic i_enable,
    input wire logic i_byte_valid,
    input wire logic [7:0] i_byte_data,
    output logic o_reinit_keep,
    output logic o_reinit_powerup,
    output logic [7:0] o_activity_led_control,
    output logic [7:0] o_synth_loop_config,
    output logic [7:0] o_tone_or_list_select,
    output logic [7:0] o_sequence_config,
    output logic [55:0] o_sweep_first_freq,
    output logic [55:0] o_sweep_last_freq,
    output logic [55:0] o_sweep_increment_freq,
    output logic [39:0] o_point_hold_time,
    output logic [39:0] o_repeat_total,
    output logic [23:0] o_table_point_total,
    output logic [55:0] o_table_entry_push,
    output logic o_table_entry_strobe,
    output logic [7:0] o_table_storage_transfer,
    output logic o_table_transfer_strobe,
    output logic o_host_trigger_strobe,
    output logic [55:0] o_output_freq_word,
    output logic o_output_freq_strobe,
    output logic [23:0] o_output_power_word,
    output logic [7:0] o_output_on_control,
    output logic o_stalled
);
    import scw_pkg::*;

    scw_state_e state_q;
    logic [7:0] addr_q;
    logic [2:0] remain_q;
    logic [55:0] shift_q;
    logic [2:0] len;
    logic [55:0] shift_d;
    logic done;

    // Payload length looked up from the address byte; zero means unknown.
    always_comb begin
        if (i_byte_data == ADDR_REINIT || i_byte_data == ADDR_LED ||
            i_byte_data == ADDR_SYNTH || i_byte_data == ADDR_TONE_LIST ||
            i_byte_data == ADDR_SEQ_CFG || i_byte_data == ADDR_UNUSED_0B ||
            i_byte_data == ADDR_TABLE_XFER ||
            i_byte_data == ADDR_HOST_TRIG ||
            i_byte_data == ADDR_OUT_ON) begin
            len = LEN_BYTE1;
        end else if (i_byte_data == ADDR_SWEEP_FIRST ||
            i_byte_data == ADDR_SWEEP_LAST ||
            i_byte_data == ADDR_SWEEP_INC ||
            i_byte_data == ADDR_TABLE_PUSH ||
            i_byte_data == ADDR_FREQ) begin
            len = LEN_BYTE7;
        end else if (i_byte_data == ADDR_HOLD_TIME ||
            i_byte_data == ADDR_REPEAT) begin
            len = LEN_BYTE5;
        end else if (i_byte_data == ADDR_TABLE_TOTAL ||
            i_byte_data == ADDR_POWER) begin
            len = LEN_BYTE3;
        end else begin
            len = RST_COUNT;
        end
    end

    assign shift_d = {shift_q[47:0], i_byte_data};
    assign done = i_enable && i_byte_valid && state_q == SCW_DATA &&
        remain_q == LEN_BYTE1;

    // Framing: address byte, then payload bytes, then a new address.
    always_ff @(posedge i_clock) begin
        if (!i_reset_n) begin
            state_q <= SCW_ADDR;
            addr_q <= RST_BYTE;
            remain_q <= RST_COUNT;
            shift_q <= RST_W56;
        end else if (i_enable && i_byte_valid) begin
            case (state_q)
                SCW_ADDR: begin
                    addr_q <= i_byte_data;
                    remain_q <= len;
                    shift_q <= RST_W56;
                    if (len == RST_COUNT) begin
                        state_q <= SCW_STALL;
                    end else begin
                        state_q <= SCW_DATA;
                    end
                end
                SCW_DATA: begin
                    shift_q <= shift_d;
                    remain_q <= remain_q - LEN_BYTE1;
                    if (remain_q == LEN_BYTE1) begin
                        state_q <= SCW_ADDR;
                    end
                end
                SCW_STALL: begin
                    state_q <= SCW_STALL;
                end
                default: begin
                    state_q <= SCW_STALL;
                end
            endcase
        end
    end

    always_ff @(posedge i_clock) begin
        if (!i_reset_n) begin
            o_stalled <= 1'b0;
        end else if (i_enable) begin
            o_stalled <= state_q == SCW_STALL ||
                (state_q == SCW_ADDR && i_byte_valid && len == RST_COUNT);
        end
    end

    // Register load on the final payload byte; nothing is readable back.
    always_ff @(posedge i_clock) begin
        if (!i_reset_n) begin
            o_activity_led_control <= RST_BYTE;
        end else if (done && addr_q == ADDR_LED) begin
            o_activity_led_control <= i_byte_data;
        end
    end

    always_ff @(posedge i_clock) begin
        if (!i_reset_n) begin
            o_synth_loop_config <= RST_BYTE;
        end else if (done && addr_q == ADDR_SYNTH) begin
            o_synth_loop_config <= i_byte_data;
        end
    end

    always_ff @(posedge i_clock) begin
        if (!i_reset_n) begin
            o_tone_or_list_select <= RST_BYTE;
        end else if (done && addr_q == ADDR_TONE_LIST) begin
            o_tone_or_list_select <= i_byte_data;
        end
    end

    always_ff @(posedge i_clock) begin
        if (!i_reset_n) begin
            o_sequence_config <= RST_BYTE;
        end else if (done && addr_q == ADDR_SEQ_CFG) begin
            o_sequence_config <= i_byte_data;
        end
    end

    always_ff @(posedge i_clock) begin
        if (!i_reset_n) begin
            o_sweep_first_freq <= RST_W56;
        end else if (done && addr_q == ADDR_SWEEP_FIRST) begin
            o_sweep_first_freq <= shift_d;
        end
    end

    always_ff @(posedge i_clock) begin
        if (!i_reset_n) begin
            o_sweep_last_freq <= RST_W56;
        end else if (done && addr_q == ADDR_SWEEP_LAST) begin
            o_sweep_last_freq <= shift_d;
        end
    end

    always_ff @(posedge i_clock) begin
        if (!i_reset_n) begin
            o_sweep_increment_freq <= RST_W56;
        end else if (done && addr_q == ADDR_SWEEP_INC) begin
            o_sweep_increment_freq <= shift_d;
        end
    end

    always_ff @(posedge i_clock) begin
        if (!i_reset_n) begin
            o_point_hold_time <= RST_W40;
        end else if (done && addr_q == ADDR_HOLD_TIME) begin
            o_point_hold_time <= shift_d[39:0];
        end
    end

    always_ff @(posedge i_clock) begin
        if (!i_reset_n) begin
            o_repeat_total <= RST_W40;
        end else if (done && addr_q == ADDR_REPEAT) begin
            o_repeat_total <= shift_d[39:0];
        end
    end

    always_ff @(posedge i_clock) begin
        if (!i_reset_n) begin
            o_table_point_total <= RST_W24;
        end else if (done && addr_q == ADDR_TABLE_TOTAL) begin
            o_table_point_total <= shift_d[23:0];
        end
    end

    always_ff @(posedge i_clock) begin
        if (!i_reset_n) begin
            o_table_entry_push <= RST_W56;
        end else if (done && addr_q == ADDR_TABLE_PUSH) begin
            o_table_entry_push <= shift_d;
        end
    end

    always_ff @(posedge i_clock) begin
        if (!i_reset_n) begin
            o_table_storage_transfer <= RST_BYTE;
        end else if (done && addr_q == ADDR_TABLE_XFER) begin
            o_table_storage_transfer <= i_byte_data;
        end
    end

    always_ff @(posedge i_clock) begin
        if (!i_reset_n) begin
            o_output_freq_word <= RST_W56;
        end else if (done && addr_q == ADDR_FREQ) begin
            o_output_freq_word <= shift_d;
        end
    end

    always_ff @(posedge i_clock) begin
        if (!i_reset_n) begin
            o_output_power_word <= RST_W24;
        end else if (done && addr_q == ADDR_POWER) begin
            o_output_power_word <= shift_d[23:0];
        end
    end

    always_ff @(posedge i_clock) begin
        if (!i_reset_n) begin
            o_output_on_control <= RST_BYTE;
        end else if (done && addr_q == ADDR_OUT_ON) begin
            o_output_on_control <= i_byte_data;
        end
    end

    // Strobes marking writes that act, one cycle long while i_enable stays high; table push, table transfer and frequency writes also store.
    always_ff @(posedge i_clock) begin
        if (!i_reset_n) begin
            o_reinit_keep <= 1'b0;
        end else if (i_enable) begin
            o_reinit_keep <= done && addr_q == ADDR_REINIT &&
                !i_byte_data[REINIT_MODE_BIT];
        end
    end

    always_ff @(posedge i_clock) begin
        if (!i_reset_n) begin
            o_reinit_powerup <= 1'b0;
        end else if (i_enable) begin
            o_reinit_powerup <= done && addr_q == ADDR_REINIT &&
                i_byte_data[REINIT_MODE_BIT];
        end
    end

    always_ff @(posedge i_clock) begin
        if (!i_reset_n) begin
            o_table_entry_strobe <= 1'b0;
        end else if (i_enable) begin
            o_table_entry_strobe <= done && addr_q == ADDR_TABLE_PUSH;
        end
    end

    always_ff @(posedge i_clock) begin
        if (!i_reset_n) begin
            o_table_transfer_strobe <= 1'b0;
        end else if (i_enable) begin
            o_table_transfer_strobe <= done && addr_q == ADDR_TABLE_XFER;
        end
    end

    always_ff @(posedge i_clock) begin
        if (!i_reset_n) begin
            o_host_trigger_strobe <= 1'b0;
        end else if (i_enable) begin
            o_host_trigger_strobe <= done && addr_q == ADDR_HOST_TRIG;
        end
    end

    always_ff @(posedge i_clock) begin
        if (!i_reset_n) begin
            o_output_freq_strobe <= 1'b0;
        end else if (i_enable) begin
            o_output_freq_strobe <= done && addr_q == ADDR_FREQ;
        end
    end
endmodule : scw_writer

// *** verif/scw_host.sv ***
/* Host-side byte source model for the register writer.
   Assumes its tasks are called just after a rising clock edge. */
`timescale 1ns/1ps
module scw_host (
    input wire logic i_clock,
    output logic o_valid,
    output logic [7:0] o_data
);
    initial begin
        o_valid = 1'b0;
        o_data = 8'hA5;
    end
    // Address byte, then n payload bytes, most significant first.
    task automatic send(input logic [7:0] a, input int n,
                        input logic [55:0] w, input int g);
        for (int i = 0; i <= n; i++) begin
            o_valid = 1'b1;
            o_data = (i == 0) ? a : w[8*(n-i) +: 8];
            @(posedge i_clock);
            #1;
            if (g > 0 && i < n) begin
                repeat (g) idle();
            end
        end
    endtask : send
    // A released data line shows the inverse of its last value.
    task automatic idle();
        o_valid = 1'b0;
        o_data = ~o_data;
        @(posedge i_clock);
        #1;
    endtask : idle
endmodule : scw_host

// *** verif/scw_writer_asserts.sv ***
/* Port checker for the register writer.
   Assumes one clock and a synchronous active-low reset. */
`timescale 1ns/1ps
module scw_writer_asserts (
    input wire logic i_clock,
    input wire logic i_reset_n,
    input wire logic i_enable,
    input wire logic i_byte_valid,
    input wire logic [7:0] i_byte_data,
    input wire logic o_reinit_keep,
    input wire logic o_reinit_powerup,
    input wire logic [55:0] o_output_freq_word,
    input wire logic o_output_freq_strobe,
    input wire logic o_stalled
);
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_reset_n);
    property p_gap; o_output_freq_strobe |=> !o_output_freq_strobe [*7];
    endproperty
    a_gap: assert property (p_gap) else $error("freq strobe too soon");
    property p_low; o_output_freq_strobe |-> $past(i_byte_valid && i_enable)
        && o_output_freq_word[7:0] == $past(i_byte_data); endproperty
    a_low: assert property (p_low) else $error("freq low byte wrong");
    property p_cause; $changed(o_output_freq_word) && $past(i_reset_n)
        |-> o_output_freq_strobe; endproperty
    a_cause: assert property (p_cause) else $error("freq word moved");
    property p_hold; o_stalled |=> o_stalled; endproperty
    a_hold: assert property (p_hold) else $error("stall released");
    property p_rise; $rose(o_stalled) |-> $past(i_byte_valid && i_enable);
    endproperty
    a_rise: assert property (p_rise) else $error("stall without byte");
    property p_quiet; o_stalled |-> !(o_output_freq_strobe || o_reinit_keep
        || o_reinit_powerup); endproperty
    a_quiet: assert property (p_quiet) else $error("pulse while stalled");
    property p_one; o_reinit_powerup |-> $past(i_byte_data[0])
        && !o_reinit_keep; endproperty
    a_one: assert property (p_one) else $error("powerup pulse wrong");
    property p_zero; o_reinit_keep |-> !$past(i_byte_data[0]); endproperty
    a_zero: assert property (p_zero) else $error("keep pulse wrong");
    c_freq: cover property (o_output_freq_strobe);
    c_stall: cover property ($rose(o_stalled));
    c_pwr: cover property (o_reinit_powerup);
endmodule : scw_writer_asserts
bind scw_writer scw_writer_asserts u_chk (.i_clock(i_clock),
    .i_reset_n(i_reset_n), .i_enable(i_enable), .i_byte_valid(i_byte_valid),
    .i_byte_data(i_byte_data), .o_reinit_keep(o_reinit_keep),
    .o_reinit_powerup(o_reinit_powerup), .o_stalled(o_stalled),
    .o_output_freq_word(o_output_freq_word),
    .o_output_freq_strobe(o_output_freq_strobe));

// *** verif/scw_writer_test.sv ***
/* Self-checking bench for the register writer.
   Assumes the host model and checker are compiled first. */
`timescale 1ns/1ps
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin \
 mismatches++; $display("ERROR t=%0t got=%h exp=%h", $time, g, e); end end
module scw_writer_test;
    import scw_pkg::*;
    logic i_clock, i_reset_n, i_enable, i_byte_valid;
    logic [7:0] i_byte_data, a, o_led, o_synth, o_tone, o_seq, o_xfer, o_on;
    logic o_keep, o_pwr, o_entry_s, o_xfer_s, o_trig_s, o_freq_s, o_stalled;
    logic [55:0] o_first, o_last, o_inc, o_push, o_freq, w, f1;
    logic [39:0] o_hold, o_rep;
    logic [23:0] o_total, o_power;
    int mismatches = 0, samples_checked = 0;
    wire logic [5:0] strb = {o_keep, o_pwr, o_entry_s, o_xfer_s, o_trig_s,
        o_freq_s};
    scw_host host (.i_clock(i_clock), .o_valid(i_byte_valid),
        .o_data(i_byte_data));
    scw_writer dut (.i_clock(i_clock), .i_reset_n(i_reset_n),
        .i_enable(i_enable), .i_byte_valid(i_byte_valid),
        .i_byte_data(i_byte_data), .o_reinit_keep(o_keep),
        .o_reinit_powerup(o_pwr), .o_activity_led_control(o_led),
        .o_synth_loop_config(o_synth), .o_tone_or_list_select(o_tone),
        .o_sequence_config(o_seq), .o_sweep_first_freq(o_first),
        .o_sweep_last_freq(o_last), .o_sweep_increment_freq(o_inc),
        .o_point_hold_time(o_hold), .o_repeat_total(o_rep),
        .o_table_point_total(o_total), .o_table_entry_push(o_push),
        .o_table_entry_strobe(o_entry_s), .o_table_storage_transfer(o_xfer),
        .o_table_transfer_strobe(o_xfer_s), .o_host_trigger_strobe(o_trig_s),
        .o_output_freq_word(o_freq), .o_output_freq_strobe(o_freq_s),
        .o_output_power_word(o_power), .o_output_on_control(o_on),
        .o_stalled(o_stalled));
    function automatic int plen(input logic [7:0] r);
        case (r)
            8'h06, 8'h07, 8'h08, 8'h0D, 8'h10: return 7;
            8'h09, 8'h0A: return 5;
            8'h0C, 8'h11: return 3;
            default: return 1;
        endcase
    endfunction : plen
    function automatic logic [55:0] fit(input logic [7:0] r,
                                        input logic [55:0] v);
        case (r)
            8'h01, 8'h02, 8'h04, 8'h0B, 8'h0E, 8'h12: return v & 56'h1;
            8'h03: return v & 56'h7;
            8'h0F: return 56'h0;
            8'h09, 8'h0A: return v & 56'hFFFFFFFF;
            8'h0C, 8'h11: return v & 56'hFFFF;
            default: return v & ((56'h1 << (8 * plen(r))) - 56'h1);
        endcase
    endfunction : fit
    function automatic logic [5:0] strb_of(input logic [7:0] r,
                                           input logic [55:0] v);
        return {r == ADDR_REINIT && !v[0], r == ADDR_REINIT && v[0],
            r == ADDR_TABLE_PUSH, r == ADDR_TABLE_XFER,
            r == ADDR_HOST_TRIG, r == ADDR_FREQ};
    endfunction : strb_of
    function automatic logic [55:0] reg_of(input logic [7:0] r,
                                           input logic [55:0] e);
        case (r)
            8'h02: return 56'(o_led);
            8'h03: return 56'(o_synth);
            8'h04: return 56'(o_tone);
            8'h05: return 56'(o_seq);
            8'h06: return o_first;
            8'h07: return o_last;
            8'h08: return o_inc;
            8'h09: return 56'(o_hold);
            8'h0A: return 56'(o_rep);
            8'h0C: return 56'(o_total);
            8'h0D: return o_push;
            8'h0E: return 56'(o_xfer);
            8'h10: return o_freq;
            8'h11: return 56'(o_power);
            8'h12: return 56'(o_on);
            default: return e;
        endcase
    endfunction : reg_of
    task automatic conclude();
        $display("checks=%0d mismatches=%0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : conclude
    initial begin
        i_clock = 1'b0;
        forever #4 i_clock = ~i_clock;
    end
    initial begin
        #400000;
        mismatches++;
        conclude();
    end
    initial begin
        void'($urandom(56));
        i_reset_n = 1'b0;
        i_enable = 1'b1;
        repeat (2) @(posedge i_clock);
        #1;
        i_reset_n = 1'b1;
        repeat (3) begin
            for (int r = 1; r <= 18; r++) begin
                a = 8'(r);
                w = fit(a, 56'({$urandom, $urandom}));
                host.send(a, plen(a), w, $urandom_range(0, 2));
                `CHK(strb, strb_of(a, w))
                `CHK(reg_of(a, w), w)
                if ($urandom_range(0, 1) == 1) host.idle();
            end
        end
        for (int b = 0; b < 2; b++) begin
            host.send(ADDR_REINIT, 1, 56'(b), 0);
            `CHK(strb, {b == 0, b == 1, 4'h0})
        end
        host.send(ADDR_FREQ, 7, 56'h123456789ABCDE, 0);
        f1 = 56'({$urandom, $urandom});
        host.send(ADDR_FREQ, 7, f1, 0);
        `CHK({o_freq_s, o_freq}, {1'b1, f1})
        host.idle();
        i_enable = 1'b0;
        host.send(ADDR_FREQ, 7, ~f1, 0);
        i_enable = 1'b1;
        host.idle();
        `CHK({o_freq_s, o_freq}, {1'b0, f1})
        host.send(8'h13, 0, 56'h0, 0);
        host.send(ADDR_FREQ, 7, ~f1, 0);
        host.idle();
        `CHK({o_stalled, o_freq}, {1'b1, f1})
        i_reset_n = 1'b0;
        @(posedge i_clock);
        #1;
        i_reset_n = 1'b1;
        `CHK({o_stalled, o_freq}, 57'h0)
        conclude();
    end
endmodule : scw_writer_test
